// file: rtl/audio_port_pkg.sv
// shared constants and types for the serial audio port
package audio_port_pkg;
    localparam int WORD_MAX = 24;
    localparam int PAIR_W = 2 * WORD_MAX;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] FMT_I2S = 2'h0;
    localparam logic [1:0] FMT_LEFT_JUST = 2'h1;
    localparam logic [1:0] FMT_DSP = 2'h2;
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_20 = 2'h2;
    localparam logic [1:0] WIDTH_24 = 2'h3;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_16 = 5'h10;
    localparam logic [4:0] BITS_20 = 5'h14;
    localparam logic [4:0] BITS_24 = 5'h18;
    localparam int SYS_PERIOD_NS = 100;
    localparam int BCLK_MIN_PERIOD_NS = 800;
    localparam int SYS_PER_BCLK = BCLK_MIN_PERIOD_NS / SYS_PERIOD_NS;
    typedef enum logic [2:0] {
        st_idle = 3'h1,
        st_arm = 3'h2,
        st_shift = 3'h4
    } state_type;
endpackage : audio_port_pkg

// file: rtl/stereo_stream_if.sv
// stereo sample pair stream between the port and its buffer
`timescale 1ns/1ps
interface stereo_stream_if;
    logic [audio_port_pkg::PAIR_W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : stereo_stream_if

// file: rtl/stereo_pair_buffer.sv
// two-entry buffer for stereo sample pairs
`timescale 1ns/1ps
module stereo_pair_buffer (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // streams
    stereo_stream_if.snk fill,
    stereo_stream_if.src drain
);
    logic [audio_port_pkg::PAIR_W-1:0] mem [audio_port_pkg::BUF_DEPTH];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    assign fill.ready = (count != 2'h2);
    assign drain.valid = (count != 2'h0);
    assign drain.data = mem[rd_ptr];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= fill.data;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end

    a_buf_no_overflow: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) count <= 2'h2)
        else $error("buffer count above depth");
endmodule : stereo_pair_buffer

// file: rtl/audio_serial_port.sv
// slave serial audio transmitter: i2s, left-justified and dsp framing
`timescale 1ns/1ps
module audio_serial_port (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // link pins
    input wire logic bit_clock_i,
    input wire logic frame_sync_i,
    output logic serial_data_o,
    // configuration
    input wire logic digital_out_enable_i,
    input wire logic [1:0] format_i,
    input wire logic [1:0] width_sel_i,
    input wire logic capture_falling_i,
    input wire logic dsp_late_msb_i,
    // sample pairs, left in upper half, each word msb-aligned
    input wire logic [audio_port_pkg::PAIR_W-1:0] pair_data_i,
    input wire logic pair_valid_i,
    output logic pair_ready_o,
    // status
    output logic underrun_o
);
    localparam int W = audio_port_pkg::WORD_MAX;

    stereo_stream_if in_s ();
    stereo_stream_if out_s ();

    logic bclk_meta, bclk_s, bclk_d;
    logic fs_meta, fs_s, fs_d;
    logic bclk_rise, bclk_fall, capture_edge, launch_edge;
    logic fs_rise, fs_fall, frame_event;
    logic start_left, delay_one, load_now, load_left;
    logic armed_cap, arm_left, on_left;
    logic [4:0] width_bits;
    logic [W-1:0] width_mask;
    logic [W-1:0] shreg;
    logic [W-1:0] right_hold;
    logic [W-1:0] load_word;
    logic [4:0] bit_count;
    logic dsp_chain;
    audio_port_pkg::state_type state;

    assign in_s.data = pair_data_i;
    assign in_s.valid = pair_valid_i;
    assign pair_ready_o = in_s.ready;

    stereo_pair_buffer u_buffer (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .fill(in_s.snk),
        .drain(out_s.src)
    );

    // both clocks are the master's; the port only listens
    // oversampling needs bit clock at most an eighth of clk_sys
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bclk_meta <= 1'b0;
            bclk_s <= 1'b0;
            bclk_d <= 1'b0;
            fs_meta <= 1'b0;
            fs_s <= 1'b0;
            fs_d <= 1'b0;
        end else begin
            bclk_meta <= bit_clock_i;
            bclk_s <= bclk_meta;
            bclk_d <= bclk_s;
            fs_meta <= frame_sync_i;
            fs_s <= fs_meta;
            fs_d <= fs_s;
        end
    end

    assign bclk_rise = bclk_s && !bclk_d;
    assign bclk_fall = !bclk_s && bclk_d;
    assign capture_edge = capture_falling_i ? bclk_fall : bclk_rise;
    assign launch_edge = capture_falling_i ? bclk_rise : bclk_fall;
    assign fs_rise = fs_s && !fs_d;
    assign fs_fall = !fs_s && fs_d;

    // dsp framing keys on the pulse's leading edge only
    always_comb begin
        frame_event = 1'b0;
        start_left = 1'b1;
        delay_one = 1'b0;
        case (format_i)
            audio_port_pkg::FMT_I2S: begin
                frame_event = fs_rise || fs_fall;
                start_left = !fs_s;
                delay_one = 1'b1;
            end
            audio_port_pkg::FMT_LEFT_JUST: begin
                frame_event = fs_rise || fs_fall;
                start_left = fs_s;
                delay_one = 1'b0;
            end
            audio_port_pkg::FMT_DSP: begin
                frame_event = fs_rise;
                start_left = 1'b1;
                delay_one = dsp_late_msb_i;
            end
            default: begin
                frame_event = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (width_sel_i)
            audio_port_pkg::WIDTH_8: width_bits = audio_port_pkg::BITS_8;
            audio_port_pkg::WIDTH_16: width_bits = audio_port_pkg::BITS_16;
            audio_port_pkg::WIDTH_20: width_bits = audio_port_pkg::BITS_20;
            audio_port_pkg::WIDTH_24: width_bits = audio_port_pkg::BITS_24;
            default: width_bits = audio_port_pkg::BITS_24;
        endcase
    end

    // bits below the word width are cleared so the tail shifts out zeros
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_mask
            assign width_mask[gi] = (5'(W - gi) <= width_bits);
        end
    endgenerate

    // a word starts at once, after one bit, or chained in dsp framing
    assign dsp_chain = (state == audio_port_pkg::st_shift) && launch_edge
        && (bit_count == 5'h00) && on_left
        && (format_i == audio_port_pkg::FMT_DSP);
    always_comb begin
        load_now = 1'b0;
        load_left = 1'b0;
        if (digital_out_enable_i && frame_event && !delay_one) begin
            load_now = 1'b1;
            load_left = start_left;
        end else if (state == audio_port_pkg::st_arm && launch_edge
                && armed_cap && !frame_event) begin
            load_now = 1'b1;
            load_left = arm_left;
        end else if (dsp_chain) begin
            load_now = 1'b1;
            load_left = 1'b0;
        end
    end

    // an empty buffer sends silence rather than stale samples
    assign out_s.ready = load_now && load_left;
    assign load_word = (load_left
        ? (out_s.valid ? out_s.data[2*W-1:W] : '0)
        : right_hold) & width_mask;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            right_hold <= '0;
            underrun_o <= 1'b0;
        end else if (out_s.ready) begin
            right_hold <= out_s.valid ? out_s.data[W-1:0] : '0;
            underrun_o <= !out_s.valid;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= audio_port_pkg::st_idle;
            armed_cap <= 1'b0;
            arm_left <= 1'b0;
            on_left <= 1'b0;
            bit_count <= 5'h00;
        end else if (!digital_out_enable_i) begin
            state <= audio_port_pkg::st_idle;
            armed_cap <= 1'b0;
        end else if (load_now) begin
            state <= audio_port_pkg::st_shift;
            on_left <= load_left;
            bit_count <= width_bits - 5'h01;
        end else if (frame_event) begin
            // wait one capture edge so the msb lands on the second
            state <= audio_port_pkg::st_arm;
            arm_left <= start_left;
            armed_cap <= 1'b0;
        end else begin
            case (state)
                audio_port_pkg::st_idle: begin
                    state <= audio_port_pkg::st_idle;
                end
                audio_port_pkg::st_arm: begin
                    if (capture_edge) begin
                        armed_cap <= 1'b1;
                    end
                end
                audio_port_pkg::st_shift: begin
                    if (launch_edge) begin
                        if (bit_count == 5'h00) begin
                            state <= audio_port_pkg::st_idle;
                        end else begin
                            bit_count <= bit_count - 5'h01;
                        end
                    end
                end
                default: begin
                    state <= audio_port_pkg::st_idle;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shreg <= '0;
        end else if (!digital_out_enable_i) begin
            shreg <= '0;
        end else if (load_now) begin
            shreg <= load_word;
        end else if (launch_edge) begin
            shreg <= {shreg[W-2:0], 1'b0};
        end
    end

    assign serial_data_o = shreg[W-1];

    a_change_on_launch: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        $changed(shreg) |-> $past(launch_edge) || $past(load_now)
            || $past(!digital_out_enable_i))
        else $error("data changed off the launch edge");
    a_msb_first_shift: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        launch_edge && !load_now && digital_out_enable_i
        |=> serial_data_o == $past(shreg[W-2]))
        else $error("next bit is not the next lower bit");
    a_i2s_second_edge: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        digital_out_enable_i && frame_event
            && format_i == audio_port_pkg::FMT_I2S
        |=> state == audio_port_pkg::st_arm)
        else $error("i2s word started without one bit delay");
    a_i2s_left_low: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        load_now && frame_event && format_i == audio_port_pkg::FMT_I2S
        |-> load_left == !fs_s)
        else $error("i2s channel does not follow sync level");
    a_lj_first_edge: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        digital_out_enable_i && frame_event
            && format_i == audio_port_pkg::FMT_LEFT_JUST
        |=> state == audio_port_pkg::st_shift && on_left == $past(fs_s))
        else $error("left-justified word not started at once");
    a_dsp_no_gap: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        digital_out_enable_i && dsp_chain && !frame_event
        |=> state == audio_port_pkg::st_shift && !on_left
            && bit_count == $past(width_bits) - 5'h01)
        else $error("dsp right word did not follow left");
    a_dsp_late_msb: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        digital_out_enable_i && fs_rise && dsp_late_msb_i
            && format_i == audio_port_pkg::FMT_DSP
        |=> state == audio_port_pkg::st_arm)
        else $error("dsp late option ignored");
    a_idle_zero: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        state == audio_port_pkg::st_idle |-> !serial_data_o)
        else $error("data not zero after the last bit");
    a_word_width: assert property (@(posedge clk_sys_i)
        disable iff (!reset_n_i)
        load_now && digital_out_enable_i |-> (load_word & ~width_mask) == '0)
        else $error("bits beyond word width loaded");

    c_i2s_word: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        load_now && format_i == audio_port_pkg::FMT_I2S);
    c_lj_word: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        load_now && format_i == audio_port_pkg::FMT_LEFT_JUST);
    c_dsp_chain: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        dsp_chain);
    c_falling_capture: cover property (@(posedge clk_sys_i)
        disable iff (!reset_n_i) capture_falling_i && load_now);
endmodule : audio_serial_port

// file: test/audio_master_model.sv
// master-side model: drives bit clock and frame sync, captures data
`timescale 1ns/1ps
module audio_master_model (
    // clock
    input wire logic clk_sys_i,
    // configuration
    input wire logic capture_falling_i,
    input wire logic [1:0] format_i,
    // link pins
    output logic bit_clock_o,
    output logic frame_sync_o,
    input wire logic serial_data_i
);
    localparam int SLOTS = 64;
    localparam int HALF_NS = 400;
    logic [SLOTS-1:0] frame_bits;

    function automatic logic sync_at(input int k);
        if (format_i == audio_port_pkg::FMT_I2S) begin
            return k >= SLOTS / 2;
        end
        if (format_i == audio_port_pkg::FMT_LEFT_JUST) begin
            return k < SLOTS / 2;
        end
        return k == 0;
    endfunction : sync_at

    initial begin
        bit_clock_o = 1'b0;
        frame_sync_o = 1'b0;
        frame_bits = '0;
    end

    // park at capture level; the sync level chosen never starts a left word
    task automatic park();
        bit_clock_o = ~capture_falling_i;
        frame_sync_o = ~sync_at(0);
    endtask : park

    // clock runs only within frames; slots past the words stay idle
    task automatic run_frame();
        @(posedge clk_sys_i);
        #37;
        for (int k = 0; k < SLOTS; k++) begin
            bit_clock_o = capture_falling_i;
            frame_sync_o = sync_at(k);
            #HALF_NS;
            bit_clock_o = ~capture_falling_i;
            frame_bits[k] = serial_data_i;
            #HALF_NS;
        end
    endtask : run_frame
endmodule : audio_master_model

// file: test/testbench.sv
// self-checking bench for the serial audio port
`timescale 1ns/1ps
module testbench;
    logic clk_sys_i;
    logic reset_n_i;
    logic bit_clock;
    logic frame_sync;
    logic serial_data;
    logic enable;
    logic [1:0] format;
    logic [1:0] width_sel;
    logic capture_falling;
    logic dsp_late_msb;
    logic [47:0] pair_data;
    logic pair_valid;
    logic pair_ready;
    logic underrun;
    logic [15:0] lfsr;
    int fails;
    int n_compared;

    audio_serial_port audio_serial_port_inst (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .bit_clock_i(bit_clock),
        .frame_sync_i(frame_sync),
        .serial_data_o(serial_data),
        .digital_out_enable_i(enable),
        .format_i(format),
        .width_sel_i(width_sel),
        .capture_falling_i(capture_falling),
        .dsp_late_msb_i(dsp_late_msb),
        .pair_data_i(pair_data),
        .pair_valid_i(pair_valid),
        .pair_ready_o(pair_ready),
        .underrun_o(underrun)
    );

    audio_master_model audio_master_model_inst (
        .clk_sys_i(clk_sys_i),
        .capture_falling_i(capture_falling),
        .format_i(format),
        .bit_clock_o(bit_clock),
        .frame_sync_o(frame_sync),
        .serial_data_i(serial_data)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    function automatic logic [63:0] exp_frame(input logic [47:0] p,
            input logic [1:0] fmt, input logic [1:0] ws, input logic late);
        logic [63:0] v;
        int n;
        int off;
        int rs;
        v = '0;
        n = (ws == audio_port_pkg::WIDTH_8) ? 8 : 16 + 4 * int'(ws - 2'h1);
        off = (fmt == audio_port_pkg::FMT_I2S) ? 1 :
              (fmt == audio_port_pkg::FMT_LEFT_JUST) ? 0 : int'(late);
        rs = (fmt == audio_port_pkg::FMT_DSP) ? off + n : 32 + off;
        for (int j = 0; j < n; j++) begin
            v[off + j] = p[47 - j];
            v[rs + j] = p[23 - j];
        end
        return v;
    endfunction : exp_frame

    task automatic check(input string what, input logic [63:0] seen,
            input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic rand_pair(output logic [47:0] p);
        for (int b = 0; b < 3; b++) begin
            lfsr = lfsr_next(lfsr);
            p[b * 16 +: 16] = lfsr;
        end
    endtask : rand_pair

    // valid stays up on return; each push drives data and valid again
    task automatic push(input logic [47:0] d);
        int t;
        t = 0;
        pair_data <= d;
        pair_valid <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            t++;
        end while (pair_ready !== 1'b1 && t < 20);
        check("pair taken", {63'h0, pair_ready}, 64'h1);
    endtask : push

    initial begin
        logic [47:0] pr [0:2];
        reset_n_i = 1'b0;
        enable = 1'b1;
        format = audio_port_pkg::FMT_I2S;
        width_sel = audio_port_pkg::WIDTH_24;
        capture_falling = 1'b0;
        dsp_late_msb = 1'b0;
        pair_data = '0;
        pair_valid = 1'b0;
        lfsr = 16'h0030;
        fails = 0;
        n_compared = 0;
        repeat (2) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        check("reset outputs", {61'h0, serial_data, pair_ready, underrun},
              64'h2);
        // every format and width; edges and dsp offset alternate
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_sys_i);
            format <= 2'(i % 3);
            width_sel <= 2'(i / 3);
            capture_falling <= 1'(i % 2);
            dsp_late_msb <= 1'((i / 3) % 2);
            @(posedge clk_sys_i);
            audio_master_model_inst.park();
            repeat (10) @(posedge clk_sys_i);
            for (int k = 0; k < 3; k++) begin
                rand_pair(pr[k]);
            end
            if (i == 0) begin
                pr[0] = 48'hffffff_ffffff;
            end
            push(pr[0]);
            push(pr[1]);
            // third pair offered to a full buffer must be refused
            pair_data <= pr[2];
            repeat (3) begin
                @(posedge clk_sys_i);
                check("full refuses", {63'h0, pair_ready}, 64'h0);
            end
            pair_valid <= 1'b0;
            for (int f = 0; f < 3; f++) begin
                audio_master_model_inst.run_frame();
                check("frame", audio_master_model_inst.frame_bits, f < 2 ?
                      exp_frame(pr[f], format, width_sel, dsp_late_msb) :
                      64'h0);
                check("underrun", {63'h0, underrun}, f < 2 ? 64'h0 : 64'h1);
            end
            check("drained", {63'h0, pair_ready}, 64'h1);
        end
        // port switched off, then unused format code: line stays low
        for (int m = 0; m < 2; m++) begin
            @(posedge clk_sys_i);
            enable <= 1'(m);
            format <= (m == 0) ? audio_port_pkg::FMT_LEFT_JUST : 2'h3;
            @(posedge clk_sys_i);
            audio_master_model_inst.park();
            repeat (10) @(posedge clk_sys_i);
            audio_master_model_inst.run_frame();
            check("silent", audio_master_model_inst.frame_bits, 64'h0);
        end
        tally_and_finish();
    end

    // about 40 frames of 51.2 us each, with ample margin
    initial begin
        #6000000;
        fails++;
        tally_and_finish();
    end
endmodule : testbench
